// ===== src/itsh_terminal_block.sv
// Contract
// - Mode input off: run PI compensation.
// - Mode input on: proportional only, no integral.
// - Mode input exists only where code 43 assigned.
// - No code 43 assigned: always PI.
// - Switching only under vector methods 03/04/05.
// - P-only gain 0.001 to 10.00 used.
// - PI gains accept 0.0 to 1000 percent.
// - Speed variation equals ten over P gain.
// - Hold active freezes analog frequency command.
// - Up/down adjusts from the frozen value.
// - Memory setting 01 stores adjusted result.
// - Restart under hold uses previous held value.
// - Count pulses, expose on counter monitor.
// - Counter cleared at power-on and reset.
// - Clear input zeroes the counter.
// - Fast pulses beyond response limit not counted.
`timescale 1ns/1ps

`include "itsh_regs.svh"

module itsh_terminal_block
	import itsh_pkg::*;
#(
	parameter int          TERMS        = 8,
	parameter int          FREQ_W       = 16,
	parameter int          COUNT_W      = 32,
	parameter int          TICK_CYCLES  = `ITSH_SAMPLE_CYCLES,
	parameter logic [15:0] UD_STEP      = 16'h0001
) (
	input  wire logic                   sys_clk,
	input  wire logic                   reset_n,
	input  wire logic [TERMS-1:0]       term_level,
	input  wire logic [TERMS-1:0][7:0]  input_terminal_function_sel,
	input  wire logic [TERMS-1:0][7:0]  input_response_time,
	input  wire logic [7:0]             motor_control_method,
	input  wire logic [7:0]             updown_memory_sel,
	input  wire logic [13:0]            pi_prop_gain,
	input  wire logic [13:0]            pi_integral_gain,
	input  wire logic [13:0]            p_only_gain,
	input  wire logic                   reset_input,
	input  wire logic [FREQ_W-1:0]      analog_freq,
	input  wire itsh_retain_t           retained_in,
	output itsh_comp_mode_t             comp_mode,
	output itsh_loop_gain_t             loop_gain,
	output logic [19:0]                 speed_variation,
	output logic                        speed_variation_valid,
	output logic [FREQ_W-1:0]           freq_command,
	output itsh_retain_t                retained_out,
	output logic                        retained_wr,
	output logic [COUNT_W-1:0]          pulse_counter_monitor
);

	// ======================================================================
	// Elaboration checks.
	if (TERMS < 1 || TERMS > 8)
		$error("itsh_terminal_block: TERMS must be 1 to 8");
	if (FREQ_W != 16)
		$error("itsh_terminal_block: FREQ_W must be 16 to match retained words");
	if (TICK_CYCLES < 2 || COUNT_W < 8)
		$error("itsh_terminal_block: TICK_CYCLES or COUNT_W too small");

	// ======================================================================
	// Sample tick divider.

	// A full 32-bit count so that slow sample periods need no width change.
	logic [31:0] tick_count;
	wire         sample_tick = tick_count == 32'(TICK_CYCLES - 1);

	// One enable pulse per sample period drives every terminal filter.
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			tick_count <= 32'h0000_0000;
		end else begin
			tick_count <= sample_tick ? 32'h0000_0000 : tick_count + 32'h0000_0001;
		end
	end

	// ======================================================================
	// Terminal filters and function decode.

	logic [TERMS-1:0] term_filtered;

	for (genvar t = 0; t < TERMS; t++) begin : g_term
		itsh_term_filter u_filter (
			.sys_clk     (sys_clk),
			.reset_n     (reset_n),
			.sample_tick (sample_tick),
			.raw         (term_level[t]),
			.resp_time   (input_response_time[t]),
			.level       (term_filtered[t])
		);
	end

	// Each function is the OR of every terminal that carries its code.
	function automatic logic [1:0] fn_state(
		input logic [TERMS-1:0][7:0] sel,
		input logic [TERMS-1:0]      lvl,
		input logic [TERMS-1:0]      raw,
		input logic [7:0]            code
	);
		logic [1:0] acc;
		acc = 2'b00;
		for (int i = 0; i < TERMS; i++) begin
			if (sel[i] == code) begin
				acc[0] = acc[0] | lvl[i];
				acc[1] = acc[1] | raw[i];
			end
		end
		return acc;
	endfunction : fn_state

	// Bit 0 is the filtered function level, bit 1 the raw terminal level.
	wire [1:0] p_only_fn = fn_state(input_terminal_function_sel, term_filtered, term_level, `ITSH_FN_P_ONLY);
	wire [1:0] hold_fn   = fn_state(input_terminal_function_sel, term_filtered, term_level, `ITSH_FN_ANALOG_HOLD);
	wire [1:0] up_fn     = fn_state(input_terminal_function_sel, term_filtered, term_level, `ITSH_FN_UP);
	wire [1:0] down_fn   = fn_state(input_terminal_function_sel, term_filtered, term_level, `ITSH_FN_DOWN);
	wire [1:0] pulse_fn  = fn_state(input_terminal_function_sel, term_filtered, term_level, `ITSH_FN_PULSE_COUNT);
	wire [1:0] clear_fn  = fn_state(input_terminal_function_sel, term_filtered, term_level, `ITSH_FN_PULSE_CLEAR);

	// ======================================================================
	// Compensation mode and gain selection.

	// A terminal without code 43 never drives the mode, so the OR stays low.
	wire vector_method = motor_control_method == `ITSH_METHOD_SLV
	                  || motor_control_method == `ITSH_METHOD_SLV_0HZ
	                  || motor_control_method == `ITSH_METHOD_VECTOR;
	wire mode_input    = p_only_fn[0];
	wire p_only_now    = mode_input && vector_method;

	// Settings outside their range are clamped rather than refused.
	wire [13:0] p_gain_clamped  = (p_only_gain < `ITSH_P_GAIN_MIN) ? `ITSH_P_GAIN_MIN
	                            : (p_only_gain > `ITSH_P_GAIN_MAX) ? `ITSH_P_GAIN_MAX
	                            : p_only_gain;
	wire [13:0] pi_prop_clamped = (pi_prop_gain > `ITSH_PI_GAIN_MAX) ? `ITSH_PI_GAIN_MAX
	                            : pi_prop_gain;
	wire [13:0] pi_int_clamped  = (pi_integral_gain > `ITSH_PI_GAIN_MAX) ? `ITSH_PI_GAIN_MAX
	                            : pi_integral_gain;

	itsh_loop_gain_t next_loop_gain;
	always_comb begin
		next_loop_gain = '0;
		if (p_only_now) begin
			next_loop_gain.prop     = p_gain_clamped;
			next_loop_gain.integ    = 14'h0000;
			next_loop_gain.integ_en = 1'b0;
		end else begin
			next_loop_gain.prop     = pi_prop_clamped;
			next_loop_gain.integ    = pi_int_clamped;
			next_loop_gain.integ_en = 1'b1;
		end
	end

	// Registered so the speed loop sees the mode and gains change together.
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			comp_mode <= ITSH_MODE_PI;
			loop_gain <= '0;
		end else begin
			comp_mode <= p_only_now ? ITSH_MODE_P : ITSH_MODE_PI;
			loop_gain <= next_loop_gain;
		end
	end

	// ======================================================================
	// Speed variation estimate, 10 % divided by the P-only gain.

	typedef enum {DIV_IDLE, DIV_RUN} itsh_div_state_t;
	itsh_div_state_t div_state;
	logic [13:0] div_divisor;
	logic [14:0] div_rem;
	logic [19:0] div_quo;
	logic [4:0]  div_step;
	wire  [14:0] rem_shift  = {div_rem[13:0], div_quo[19]};
	wire         rem_ge     = rem_shift >= {1'b0, div_divisor};
	wire  [14:0] rem_sub    = rem_shift - {1'b0, div_divisor};
	wire         gain_moved = p_gain_clamped != div_divisor;

	// A restoring divider, 20 steps; the result is redone when the gain moves.
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			div_state             <= DIV_IDLE;
			div_divisor           <= 14'h0000;
			div_rem               <= 15'h0000;
			div_quo               <= 20'h00000;
			div_step              <= 5'h00;
			speed_variation       <= 20'h00000;
			speed_variation_valid <= 1'b0;
		end else begin
			unique case (div_state)
				DIV_IDLE: begin
					if (gain_moved) begin
						div_divisor           <= p_gain_clamped;
						div_rem               <= 15'h0000;
						div_quo               <= `ITSH_VAR_NUMER;
						div_step              <= 5'h00;
						speed_variation_valid <= 1'b0;
						div_state             <= DIV_RUN;
					end
				end
				DIV_RUN: begin
					div_rem  <= rem_ge ? rem_sub : rem_shift;
					div_quo  <= {div_quo[18:0], rem_ge};
					div_step <= div_step + 5'h01;
					// A gain that moved mid-division leaves the result stale, so it is
					// not flagged valid; the idle state then starts over.
					if (div_step == 5'h13) begin
						speed_variation       <= {div_quo[18:0], rem_ge};
						speed_variation_valid <= !gain_moved;
						div_state             <= DIV_IDLE;
					end
				end
			endcase
		end
	end

	// ======================================================================
	// Internal restart: power-on release or the reset terminal released.

	// A falling reset terminal restarts the hold logic just as power-on does.
	logic restore_pending;
	logic reset_term_prev;
	wire  restore_now = restore_pending || (reset_term_prev && !reset_input);

	// The restart is acted on one clock after reset_n rises, never under it.
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			restore_pending <= 1'b1;
			reset_term_prev <= 1'b0;
		end else begin
			restore_pending <= 1'b0;
			reset_term_prev <= reset_input;
		end
	end

	// ======================================================================
	// Analog command hold with up/down adjustment.

	// Up and down together cancel, and both are ignored outside a hold.
	logic [FREQ_W-1:0] hold_base;
	logic [FREQ_W-1:0] hold_adj;
	logic              hold_latched;
	logic              hold_prev;
	wire               hold_active = hold_fn[0] || hold_latched;
	wire               hold_rise   = hold_fn[0] && !hold_prev && !hold_latched;
	wire               ud_mem_on   = updown_memory_sel == `ITSH_UD_MEM_ON;
	wire               up_step     = sample_tick && up_fn[0] && !down_fn[0];
	wire               down_step   = sample_tick && down_fn[0] && !up_fn[0];
	wire [FREQ_W:0]    adj_up      = {1'b0, hold_adj} + {1'b0, UD_STEP};
	wire [FREQ_W-1:0]  adj_up_sat  = adj_up[FREQ_W] ? {FREQ_W{1'b1}} : adj_up[FREQ_W-1:0];
	wire [FREQ_W-1:0]  adj_dn_sat  = (hold_adj < UD_STEP) ? {FREQ_W{1'b0}} : hold_adj - UD_STEP;

	// On restart the raw terminal decides whether the held words come back,
	// because the filtered level needs a few samples to settle.
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			hold_base    <= '0;
			hold_adj     <= '0;
			hold_latched <= 1'b0;
			hold_prev    <= 1'b0;
		end else begin
			hold_prev <= hold_fn[0];
			if (restore_now) begin
				hold_latched <= hold_fn[1];
				hold_base    <= retained_in.base;
				hold_adj     <= ud_mem_on ? retained_in.adj : retained_in.base;
			end else if (reset_input) begin
				hold_latched <= hold_latched;
			end else begin
				if (!hold_fn[1]) begin
					hold_latched <= 1'b0;
				end
				if (hold_rise) begin
					hold_base <= analog_freq;
					hold_adj  <= analog_freq;
				end else if (hold_active && up_step) begin
					hold_adj <= adj_up_sat;
				end else if (hold_active && down_step) begin
					hold_adj <= adj_dn_sat;
				end
			end
		end
	end

	// Live analog follows through only while no hold is in force.
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			freq_command <= '0;
		end else begin
			freq_command <= hold_active ? hold_adj : analog_freq;
		end
	end

	// ======================================================================
	// Retained memory write-back.

	itsh_retain_t next_retained;
	always_comb begin
		next_retained.base = hold_base;
		next_retained.adj  = ud_mem_on ? hold_adj : hold_base;
	end

	// A write pulse is raised only when the retained words actually change.
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			retained_out <= '0;
			retained_wr  <= 1'b0;
		end else begin
			retained_wr  <= 1'b0;
			if (!restore_now && !reset_input && next_retained != retained_out) begin
				retained_out <= next_retained;
				retained_wr  <= 1'b1;
			end
		end
	end

	// ======================================================================
	// Cumulative pulse counter.

	// Edge detect on the filtered level; a clear wins over a same-cycle edge.
	logic pulse_prev;
	wire  pulse_rise = pulse_fn[0] && !pulse_prev;
	wire  count_zero = clear_fn[0] || reset_input;

	// Pulses above the filter limit never reach pulse_fn[0], so they are lost;
	// sources should stay well below it.
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			pulse_prev            <= 1'b0;
			pulse_counter_monitor <= COUNT_W'(`ITSH_COUNT_CLEAR);
		end else begin
			pulse_prev <= pulse_fn[0];
			if (count_zero) begin
				pulse_counter_monitor <= COUNT_W'(`ITSH_COUNT_CLEAR);
			end else if (pulse_rise) begin
				pulse_counter_monitor <= pulse_counter_monitor + COUNT_W'(1);
			end
		end
	end

endmodule : itsh_terminal_block

// ===== pkg/itsh_regs.svh
`ifndef ITSH_REGS_SVH
`define ITSH_REGS_SVH

// ==========================================================================
// Input terminal function codes.
`define ITSH_FN_UP            8'h1B
`define ITSH_FN_DOWN          8'h1C
`define ITSH_FN_P_ONLY        8'h2B
`define ITSH_FN_ANALOG_HOLD   8'h41
`define ITSH_FN_PULSE_COUNT   8'h4A
`define ITSH_FN_PULSE_CLEAR   8'h4B

// ==========================================================================
// Motor control method codes that select a vector-control method.
`define ITSH_METHOD_SLV       8'h03
`define ITSH_METHOD_SLV_0HZ   8'h04
`define ITSH_METHOD_VECTOR    8'h05

// Up/down memory setting value that enables retention.
`define ITSH_UD_MEM_ON        8'h01

// ==========================================================================
// Gain limits. P-only gain is in units of 0.001, PI gains in units of 0.1 %.
`define ITSH_P_GAIN_MIN       14'h0001
`define ITSH_P_GAIN_MAX       14'h2710
`define ITSH_PI_GAIN_MAX      14'h2710

// Speed variation numerator: 10 % in units of 0.01 %, over a gain in 0.001.
`define ITSH_VAR_NUMER        20'hF4240

// ==========================================================================
// Terminal sampling: one sample every 2000 us at a 125 MHz clock.
`define ITSH_SAMPLE_PERIOD_US 2000
`define ITSH_CLK_MHZ          125
`define ITSH_SAMPLE_CYCLES    (`ITSH_SAMPLE_PERIOD_US * `ITSH_CLK_MHZ)

// Cumulative counter value after any clear.
`define ITSH_COUNT_CLEAR      32'h0000_0000

`endif

// ===== pkg/itsh_pkg.sv
package itsh_pkg;

	// ======================================================================
	// Speed loop compensation mode.
	typedef enum logic {
		ITSH_MODE_PI,
		ITSH_MODE_P
	} itsh_comp_mode_t;

	// Gain set handed to the speed loop.
	typedef struct packed {
		logic [13:0] prop;
		logic [13:0] integ;
		logic        integ_en;
	} itsh_loop_gain_t;

	// Frequency words kept in or restored from retained memory.
	typedef struct packed {
		logic [15:0] adj;
		logic [15:0] base;
	} itsh_retain_t;

endpackage : itsh_pkg

// ===== src/itsh_term_filter.sv
`timescale 1ns/1ps

// ==========================================================================
// Response-time filter for one input terminal.
module itsh_term_filter (
	input  wire logic       sys_clk,
	input  wire logic       reset_n,
	input  wire logic       sample_tick,
	input  wire logic       raw,
	input  wire logic [7:0] resp_time,
	output logic            level
);

	logic [8:0] diff_count;
	wire  [8:0] accept_at = {1'b0, resp_time} + 9'h001;
	wire        differs   = raw != level;

	// A new level is taken after resp_time + 2 samples that all disagree,
	// so a half period of exactly (resp_time + 1) samples is rejected.
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			level      <= 1'b0;
			diff_count <= 9'h000;
		end else if (sample_tick) begin
			if (!differs) begin
				diff_count <= 9'h000;
			end else if (diff_count == accept_at) begin
				level      <= raw;
				diff_count <= 9'h000;
			end else begin
				diff_count <= diff_count + 9'h001;
			end
		end
	end

endmodule : itsh_term_filter

// ===== verif/itsh_switch_model.sv
`timescale 1ns/1ps

// ==========================================================================
// External contacts: static levels, plus a square pulse train on terminal 2.
module itsh_switch_model (
	input  wire logic       sys_clk,
	input  wire logic [7:0] lvl,
	input  wire logic       train_on,
	input  wire logic [7:0] half_cyc,
	output logic      [7:0] term_level,
	output logic     [15:0] sent
);
	logic       ph = 1'b0;
	logic [7:0] cnt = 8'h00;

	initial sent = 16'h0000;

	// The train moves after the falling edge, clear of the sampling edge.
	// Slow trains stay at or under the rate the counter can follow.
	always @(negedge sys_clk) begin
		if (!train_on) begin
			ph <= 1'b0;
			cnt <= 8'h00;
		end else if (cnt == half_cyc - 8'h01) begin
			cnt <= 8'h00;
			ph <= !ph;
			sent <= sent + {15'h0000, !ph};
		end else begin
			cnt <= cnt + 8'h01;
		end
	end

	// An idle train falls back to the static contact level.
	assign term_level = {lvl[7:3], train_on ? ph : lvl[2], lvl[1:0]};
endmodule : itsh_switch_model

// ===== verif/itsh_chk.sv
`timescale 1ns/1ps

`include "itsh_regs.svh"

// ==========================================================================
// Port-level checks on mode choice, gains, stored words and the counter.
module itsh_chk
	import itsh_pkg::*;
#(
	parameter int TERMS   = 8,
	parameter int COUNT_W = 32
) (
	input wire logic                  sys_clk,
	input wire logic                  reset_n,
	input wire logic [TERMS-1:0][7:0] input_terminal_function_sel,
	input wire logic [7:0]            motor_control_method,
	input wire logic [13:0]           pi_prop_gain,
	input wire logic [13:0]           p_only_gain,
	input wire logic                  reset_input,
	input wire itsh_comp_mode_t       comp_mode,
	input wire itsh_loop_gain_t       loop_gain,
	input wire logic [19:0]           speed_variation,
	input wire logic                  speed_variation_valid,
	input wire itsh_retain_t          retained_out,
	input wire logic                  retained_wr,
	input wire logic [COUNT_W-1:0]    pulse_counter_monitor
);
	logic has_sel;
	logic vec;
	logic gain_ok;

	// ======================================================================
	// Helper decodes; a P-only gain outside range is clamped, so it is skipped.
	always_comb begin
		has_sel = 1'b0;
		for (int i = 0; i < TERMS; i++) begin
			has_sel |= (input_terminal_function_sel[i] == `ITSH_FN_P_ONLY);
		end
	end
	assign vec = motor_control_method inside {`ITSH_METHOD_SLV, `ITSH_METHOD_SLV_0HZ, `ITSH_METHOD_VECTOR};
	assign gain_ok = (p_only_gain != 14'h0000) && (p_only_gain <= `ITSH_P_GAIN_MAX);

	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!reset_n);

	// ======================================================================
	// Assertions.
	a_p_gain_used: assert property ((comp_mode == ITSH_MODE_P)[*2] ##0 ($stable(p_only_gain) && gain_ok)
		|-> !loop_gain.integ_en && loop_gain.prop == p_only_gain) else $error("P gain set wrong");
	a_pi_gain_used: assert property ((comp_mode == ITSH_MODE_PI)[*3] ##0 $stable(pi_prop_gain)
		|-> loop_gain.integ_en && loop_gain.prop == pi_prop_gain) else $error("PI gain set wrong");
	a_no_sel_pi: assert property ((!has_sel)[*2] |-> comp_mode == ITSH_MODE_PI)
		else $error("P mode with no selecting terminal");
	a_vector_only: assert property ((!vec)[*2] |-> comp_mode == ITSH_MODE_PI)
		else $error("P mode outside vector methods");
	a_var_value: assert property (speed_variation_valid && gain_ok && $stable(p_only_gain)
		|-> speed_variation == `ITSH_VAR_NUMER / 20'(p_only_gain)) else $error("speed variation wrong");
	a_var_drop: assert property ($changed(p_only_gain) |=> !speed_variation_valid)
		else $error("variation valid kept over a gain change");
	a_count_step: assert property ($changed(pulse_counter_monitor)
		|-> pulse_counter_monitor == $past(pulse_counter_monitor) + 1'b1 || pulse_counter_monitor == '0)
		else $error("counter jumped");
	a_reset_clear: assert property (reset_input[*2] |-> pulse_counter_monitor == '0 && !retained_wr)
		else $error("counter or write live in reset");
	a_write_pulse: assert property (retained_wr |-> $changed(retained_out) ##1 !retained_wr)
		else $error("stored word write malformed");
endmodule : itsh_chk

bind itsh_terminal_block itsh_chk #(.TERMS(TERMS), .COUNT_W(COUNT_W)) u_chk (.sys_clk, .reset_n,
	.input_terminal_function_sel, .motor_control_method, .pi_prop_gain, .p_only_gain, .reset_input,
	.comp_mode, .loop_gain, .speed_variation, .speed_variation_valid, .retained_out, .retained_wr,
	.pulse_counter_monitor);

// ===== verif/tb_top.sv
`timescale 1ns/1ps

`include "itsh_regs.svh"

// ==========================================================================
// Self-checking bench; a short sample period keeps the filter waits small.
module tb_top
	import itsh_pkg::*;
;
	logic            sys_clk;
	logic            reset_n = 1'b0;
	logic [7:0]      lvl = 8'h00;
	logic            train_on = 1'b0;
	logic [7:0]      half_cyc = 8'h10;
	logic [7:0]      term_level;
	logic [15:0]     sent;
	logic [7:0][7:0] sel = '0;
	logic [7:0][7:0] resp = '0;
	logic [7:0]      method = 8'h03;
	logic [7:0]      mem_sel = 8'h00;
	logic [13:0]     pi_p = 14'h01F4;
	logic [13:0]     pi_i = 14'h2710;
	logic [13:0]     p_g = 14'h03E8;
	logic            rst_term = 1'b0;
	logic [15:0]     analog = 16'h1000;
	itsh_retain_t    ret_in = '0;
	itsh_comp_mode_t comp_mode;
	itsh_loop_gain_t loop_gain;
	logic [19:0]     var_val;
	logic            var_ok;
	logic [15:0]     freq;
	itsh_retain_t    ret_out;
	logic            ret_wr;
	logic [31:0]     mon;
	int              mismatches = 0;
	int              comparisons = 0;
	int              cycles = 0;

	itsh_switch_model u_sw (.sys_clk(sys_clk), .lvl(lvl), .train_on(train_on), .half_cyc(half_cyc),
		.term_level(term_level), .sent(sent));

	itsh_terminal_block #(.TICK_CYCLES(4)) dut (.sys_clk(sys_clk), .reset_n(reset_n), .term_level(term_level),
		.input_terminal_function_sel(sel), .input_response_time(resp), .motor_control_method(method),
		.updown_memory_sel(mem_sel), .pi_prop_gain(pi_p), .pi_integral_gain(pi_i), .p_only_gain(p_g),
		.reset_input(rst_term), .analog_freq(analog), .retained_in(ret_in), .comp_mode(comp_mode),
		.loop_gain(loop_gain), .speed_variation(var_val), .speed_variation_valid(var_ok),
		.freq_command(freq), .retained_out(ret_out), .retained_wr(ret_wr), .pulse_counter_monitor(mon));

	// Clock, and a cycle ceiling of 8000, well above the roughly 1300 cycles needed.
	initial begin
		sys_clk = 1'b0;
		forever #4 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 8000) begin
			mismatches++;
			results();
		end
	end

	task automatic wt(input int n);
		repeat (n) @(negedge sys_clk);
	endtask : wt

	task automatic chk(input logic ok, input string msg);
		comparisons++;
		if (ok !== 1'b1) begin
			mismatches++;
			$display("BAD %0t %s", $time, msg);
		end
	endtask : chk

	task automatic results();
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : results

	// Each vector method and method 01 with the mode terminal on and off, then with no terminal assigned.
	task automatic t_mode();
		logic [7:0] m [4] = '{8'h03, 8'h04, 8'h05, 8'h01};
		logic       v;
		sel[0] = `ITSH_FN_P_ONLY;
		foreach (m[i]) begin
			method = m[i];
			v = (i < 3);
			lvl[0] = 1'b1;
			wt(20);
			chk(comp_mode === (v ? ITSH_MODE_P : ITSH_MODE_PI), "mode on");
			chk(loop_gain.integ_en === !v && loop_gain.prop === (v ? p_g : pi_p), "gain on");
			lvl[0] = 1'b0;
			wt(20);
			chk(comp_mode === ITSH_MODE_PI && loop_gain.integ_en === 1'b1, "mode off");
			chk(loop_gain.prop === pi_p && loop_gain.integ === pi_i, "pi gains");
		end
		sel[0] = 8'h00;
		method = 8'h03;
		lvl[0] = 1'b1;
		wt(20);
		chk(comp_mode === ITSH_MODE_PI, "unassigned");
		lvl[0] = 1'b0;
		$display("test mode done");
	endtask : t_mode

	// Gain at both ends of its range and in the middle.
	task automatic t_var();
		logic [13:0] g [3] = '{14'h0001, 14'h0064, 14'h2710};
		foreach (g[i]) begin
			p_g = g[i];
			wt(30);
			chk(var_ok === 1'b1 && var_val === `ITSH_VAR_NUMER / 20'(g[i]), "variation");
		end
		p_g = 14'h03E8;
		$display("test variation done");
	endtask : t_var

	task automatic pulses(input logic [7:0] h, input int n);
		int s;
		s = int'(sent);
		half_cyc = h;
		train_on = 1'b1;
		for (int k = 0; k < 400 && int'(sent) != s + n; k++) wt(1);
		wt(int'(h) + 4);
		train_on = 1'b0;
		wt(40);
	endtask : pulses

	// Half period of resp_time + 1 samples is the refused boundary; resp_time + 2 samples count.
	task automatic t_count();
		sel[2] = `ITSH_FN_PULSE_COUNT;
		sel[3] = `ITSH_FN_PULSE_CLEAR;
		pulses(8'h10, 5);
		chk(mon === 32'h0000_0005, "slow count");
		pulses(8'h04, 10);
		chk(mon === 32'h0000_0005, "fast count");
		pulses(8'h08, 3);
		chk(mon === 32'h0000_0008, "edge rate count");
		resp[2] = 8'h01;
		pulses(8'h08, 3);
		chk(mon === 32'h0000_0008, "slow filter refuse");
		pulses(8'h0C, 2);
		chk(mon === 32'h0000_000A, "slow filter count");
		resp[2] = 8'h00;
		lvl[3] = 1'b1;
		wt(20);
		lvl[3] = 1'b0;
		wt(20);
		chk(mon === `ITSH_COUNT_CLEAR, "clear input");
		pulses(8'h10, 2);
		rst_term = 1'b1;
		wt(4);
		rst_term = 1'b0;
		wt(4);
		chk(mon === `ITSH_COUNT_CLEAR, "reset input");
		pulses(8'h10, 1);
		chk(mon === 32'h0000_0001, "recount");
		$display("test count done");
	endtask : t_count

	// Hold, move the analog input, nudge up, then restart under hold.
	task automatic t_hold();
		logic [15:0] f;
		sel[1] = `ITSH_FN_ANALOG_HOLD;
		sel[4] = `ITSH_FN_UP;
		mem_sel = `ITSH_UD_MEM_ON;
		analog = 16'h1234;
		lvl[1] = 1'b1;
		wt(20);
		analog = 16'h5678;
		wt(20);
		chk(freq === 16'h1234 && ret_out.base === 16'h1234, "held");
		lvl[4] = 1'b1;
		wt(24);
		lvl[4] = 1'b0;
		wt(20);
		chk(freq > 16'h1234 && freq < 16'h5678, "up from held");
		chk(ret_out.adj === freq && ret_out.base === 16'h1234, "stored");
		f = freq;
		sel[5] = `ITSH_FN_DOWN;
		lvl[5] = 1'b1;
		wt(16);
		lvl[5] = 1'b0;
		wt(20);
		chk(freq < f && freq >= 16'h1234, "down from adjusted");
		mem_sel = 8'h00;
		wt(2);
		chk(ret_out.adj === 16'h1234 && ret_out.base === 16'h1234, "not stored");
		mem_sel = `ITSH_UD_MEM_ON;
		ret_in = '{adj: 16'h0ABC, base: 16'h0AB0};
		reset_n = 1'b0;
		wt(2);
		reset_n = 1'b1;
		wt(20);
		chk(freq === 16'h0ABC, "restart");
		chk(mon === `ITSH_COUNT_CLEAR, "count at restart");
		lvl[1] = 1'b0;
		wt(20);
		chk(freq === analog, "released");
		$display("test hold done");
	endtask : t_hold

	// Main sequence.
	initial begin
		wt(12);
		reset_n = 1'b1;
		wt(2);
		t_mode();
		t_var();
		t_count();
		t_hold();
		results();
	end
endmodule : tb_top
